/* core/fpoc_ctrl.sv */
// Flash operation controller with AHB-Lite register slave
`include "fpoc_map.svh"
module fpoc_ctrl #(
  parameter int OP_CYC = `FPOC_OP_CYC,
  parameter logic [31:0] KEY1 = `FPOC_KEY1,
  parameter logic [31:0] KEY2 = `FPOC_KEY2
) (
  // Clock and resets
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sys_rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Flash array side
  output fpoc_pkg::fpoc_req_t flash_req,
  input fpoc_pkg::fpoc_rsp_t flash_rsp,
  input wire logic low_supply,
  output logic bank_swap
);
  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [7:0] rd_addr;
  logic wr_en;
  logic [31:0] wd;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= hsel && hready && htrans[1] && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  assign wr_en = wr_pend_r;
  assign wd = hwdata;
  assign rd_addr = haddr[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic go_r, arm_r, fail_r, low_r, swap_r;
  logic [3:0] op_r;
  logic [31:0] addr_r;
  logic [23:0] prot_r;
  logic [1:0] ecc_r;
  fpoc_pkg::fpoc_key_t key_r;
  fpoc_pkg::fpoc_st_t st_r;
  logic [31:0] cnt_r;
  logic [31:0] key_last_r;
  logic ctrl_wr, key_wr, launch;
  logic done_ev, run_fail;

  assign ctrl_wr = wr_en && hit(wr_addr_r, `FPOC_OFF_CTRL);
  assign key_wr = wr_en && hit(wr_addr_r, `FPOC_OFF_KEY);
  // Launch needs arm, completed unlock and a set attempt
  assign launch = ctrl_wr && wd[`FPOC_BIT_GO] && arm_r && !go_r &&
                  key_r == fpoc_pkg::FPOC_KEY_OPEN;

  // Key sequencer; the captured word itself is never readable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_r <= fpoc_pkg::FPOC_KEY_IDLE;
      key_last_r <= `FPOC_KEY_RST;
    end else begin
      if (key_wr) begin
        key_last_r <= wd;
        if (wd == KEY1) key_r <= fpoc_pkg::FPOC_KEY_HALF;
        else if (wd == KEY2 && key_r == fpoc_pkg::FPOC_KEY_HALF)
          key_r <= fpoc_pkg::FPOC_KEY_OPEN;
        else key_r <= fpoc_pkg::FPOC_KEY_IDLE;
      end else if (launch) begin
        key_r <= fpoc_pkg::FPOC_KEY_IDLE;
      end
    end
  end

  // Ordinary-reset registers: address, protection, ECC policy
  always_ff @(posedge hclk or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      addr_r <= 32'h0000_0000;
      prot_r <= `FPOC_PROT_RST;
      ecc_r <= 2'h0;
      swap_r <= 1'b0;
    end else if (wr_en) begin
      if (hit(wr_addr_r, `FPOC_OFF_ADDR)) addr_r <= wd;
      if (hit(wr_addr_r, `FPOC_OFF_PROT)) prot_r <= wd[23:0];
      if (hit(wr_addr_r, `FPOC_OFF_CFG)) ecc_r <= wd[1:0];
      if (ctrl_wr) swap_r <= wd[`FPOC_BIT_SWAP];
    end
  end
  assign bank_swap = swap_r;

  // Op select and arm: hresetn is the power-on reset only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arm_r <= 1'b0;
      op_r <= 4'h0;
    end else if (ctrl_wr) begin
      arm_r <= wd[`FPOC_BIT_ARM];
      if (!arm_r) op_r <= wd[`FPOC_OP_HI:0];
    end
  end

  // ----------------------------------------------------------------
  // Protection check
  // ----------------------------------------------------------------
  // Pages below the boundary are protected; boundary zero frees all
  function automatic logic prot_hit(input logic [31:0] a,
                                    input logic [23:0] b);
    prot_hit = (a[23:0] < b);
  endfunction : prot_hit

  logic [31:0] eff_addr;
  logic rejected, nop_op;
  logic [31:0] half_base;

  always_comb begin
    eff_addr = addr_r;
    half_base = 32'h0080_0000;
    rejected = 1'b0;
    nop_op = 1'b0;
    unique case (op_r)
      fpoc_pkg::FPOC_OP_NOP: nop_op = 1'b1;
      fpoc_pkg::FPOC_OP_WORD: begin
        eff_addr = {addr_r[31:2], 2'b00};
        rejected = prot_hit(eff_addr, prot_r);
        nop_op = (ecc_r == 2'h0);
      end
      fpoc_pkg::FPOC_OP_QUAD: begin
        eff_addr = {addr_r[31:4], 4'h0};
        rejected = prot_hit(eff_addr, prot_r);
      end
      fpoc_pkg::FPOC_OP_ROW: begin
        eff_addr = {addr_r[31:`FPOC_ROW_BITS],
                    {`FPOC_ROW_BITS{1'b0}}};
        rejected = prot_hit(eff_addr, prot_r);
      end
      fpoc_pkg::FPOC_OP_PAGE: begin
        eff_addr = {addr_r[31:`FPOC_PAGE_BITS],
                    {`FPOC_PAGE_BITS{1'b0}}};
        rejected = prot_hit(eff_addr, prot_r);
      end
      fpoc_pkg::FPOC_OP_LOWER: rejected = (prot_r != 24'h0);
      fpoc_pkg::FPOC_OP_UPPER:
        rejected = prot_hit(half_base, prot_r);
      fpoc_pkg::FPOC_OP_ALL: rejected = (prot_r != 24'h0);
      default: rejected = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= fpoc_pkg::FPOC_ST_IDLE;
      go_r <= 1'b0;
      cnt_r <= 32'h0;
      run_fail <= 1'b0;
      flash_req <= '0;
    end else begin
      flash_req.valid <= 1'b0;
      unique case (st_r)
        fpoc_pkg::FPOC_ST_IDLE: if (launch) begin
          go_r <= 1'b1;
          cnt_r <= 32'h0;
          run_fail <= rejected;
          if (!rejected && !nop_op) begin
            flash_req.valid <= 1'b1;
            flash_req.op <= op_r;
            flash_req.addr <= eff_addr;
            flash_req.swap <= swap_r;
            flash_req.no_ecc <= (op_r == fpoc_pkg::FPOC_OP_WORD);
            st_r <= fpoc_pkg::FPOC_ST_BUSY;
          end else begin
            st_r <= fpoc_pkg::FPOC_ST_DONE;
          end
        end
        fpoc_pkg::FPOC_ST_BUSY: begin
          cnt_r <= cnt_r + 32'h1;
          if (flash_rsp.done && cnt_r >= OP_CYC - 1) begin
            run_fail <= flash_rsp.fail;
            st_r <= fpoc_pkg::FPOC_ST_DONE;
          end
        end
        fpoc_pkg::FPOC_ST_DONE: begin
          go_r <= 1'b0;
          st_r <= fpoc_pkg::FPOC_ST_IDLE;
        end
      endcase
    end
  end

  assign done_ev = (st_r == fpoc_pkg::FPOC_ST_DONE);

  // Flags: hardware set wins over the op-0000 clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fail_r <= 1'b0;
      low_r <= 1'b0;
    end else begin
      if (done_ev && run_fail) fail_r <= 1'b1;
      else if (launch && op_r == 4'h0) fail_r <= 1'b0;
      if (st_r == fpoc_pkg::FPOC_ST_BUSY && low_supply)
        low_r <= 1'b1;
      else if (launch && op_r == 4'h0) low_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data, registered in the data phase
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (rd_addr)
        `FPOC_OFF_CTRL: hrdata <= {16'h0, go_r, arm_r, fail_r, low_r,
                                   4'h0, swap_r, 3'h0, op_r};
        `FPOC_OFF_KEY: hrdata <= 32'h0;
        `FPOC_OFF_ADDR: hrdata <= addr_r;
        `FPOC_OFF_PROT: hrdata <= {8'h0, prot_r};
        `FPOC_OFF_CFG: hrdata <= {30'h0, ecc_r};
        default: hrdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_go_needs_unlock: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(go_r) |-> $past(arm_r) && $past(key_r) == fpoc_pkg::FPOC_KEY_OPEN)
    else $error("launch set without arm and unlock");
  a_op_frozen_armed: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(arm_r) && $past(st_r) == fpoc_pkg::FPOC_ST_IDLE |-> $stable(op_r))
    else $error("op select changed while armed");
  a_fail_on_reject: assert property (@(posedge hclk) disable iff (!hresetn)
    launch && rejected |=> ##1 fail_r)
    else $error("rejected op did not flag failure");
  a_flags_clear_nop: assert property (@(posedge hclk) disable iff (!hresetn)
    launch && op_r == 4'h0 && !low_supply |=> !fail_r && !low_r)
    else $error("flags not cleared by no-op launch");
  a_low_seen: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r == fpoc_pkg::FPOC_ST_BUSY && low_supply |=> low_r)
    else $error("low supply not flagged");
  a_word_ecc_nop: assert property (@(posedge hclk) disable iff (!hresetn)
    launch && op_r == 4'h1 && ecc_r == 2'h0 |=> !flash_req.valid)
    else $error("word program issued under ECC policy 00");
  a_all_erase_prot: assert property (@(posedge hclk) disable iff (!hresetn)
    flash_req.valid && flash_req.op == 4'h7 |-> $past(prot_r) == 24'h0)
    else $error("full erase issued with protection");
  a_page_aligned: assert property (@(posedge hclk) disable iff (!hresetn)
    flash_req.valid && flash_req.op == 4'h4 |-> flash_req.addr[13:0] == 14'h0)
    else $error("page erase address not aligned");
  a_go_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    done_ev |=> !go_r)
    else $error("launch bit not cleared at finish");
endmodule : fpoc_ctrl

/* core/fpoc_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef FPOC_MAP_SVH
`define FPOC_MAP_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FPOC_OFF_CTRL 8'h00
`define FPOC_OFF_KEY 8'h04
`define FPOC_OFF_ADDR 8'h08
`define FPOC_OFF_PROT 8'h0c
`define FPOC_OFF_CFG 8'h10
// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define FPOC_BIT_GO 15
`define FPOC_BIT_ARM 14
`define FPOC_BIT_FAIL 13
`define FPOC_BIT_LOW 12
`define FPOC_BIT_SWAP 7
`define FPOC_OP_HI 3
// ----------------------------------------------------------------
// Reset values and unlock keys
// ----------------------------------------------------------------
`define FPOC_KEY_RST 32'h0000_0000
`define FPOC_KEY1 32'h1234_5678
`define FPOC_KEY2 32'h8765_4321
`define FPOC_PROT_RST 24'h00_0000
// ----------------------------------------------------------------
// Geometry and timing
// ----------------------------------------------------------------
`define FPOC_PAGE_BITS 14
`define FPOC_ROW_BITS 11
`define FPOC_OP_TIME_NS 200
`define FPOC_CLK_NS 10
`define FPOC_OP_CYC ((`FPOC_OP_TIME_NS + `FPOC_CLK_NS - 1) / `FPOC_CLK_NS)
`endif

/* core/fpoc_pkg.sv */
// Types shared by the flash operation controller
package fpoc_pkg;
  typedef enum logic [3:0] {
    FPOC_OP_NOP = 4'h0,
    FPOC_OP_WORD = 4'h1,
    FPOC_OP_QUAD = 4'h2,
    FPOC_OP_ROW = 4'h3,
    FPOC_OP_PAGE = 4'h4,
    FPOC_OP_LOWER = 4'h5,
    FPOC_OP_UPPER = 4'h6,
    FPOC_OP_ALL = 4'h7
  } fpoc_op_t;

  typedef enum logic [1:0] {
    FPOC_KEY_IDLE,
    FPOC_KEY_HALF,
    FPOC_KEY_OPEN
  } fpoc_key_t;

  typedef enum logic [1:0] {
    FPOC_ST_IDLE,
    FPOC_ST_BUSY,
    FPOC_ST_DONE
  } fpoc_st_t;

  // Request presented to the flash array
  typedef struct packed {
    logic valid;
    logic [3:0] op;
    logic [31:0] addr;
    logic swap;
    logic no_ecc;
  } fpoc_req_t;

  // Flash array answer
  typedef struct packed {
    logic done;
    logic fail;
  } fpoc_rsp_t;
endpackage : fpoc_pkg

/* bench/test_flash_program_op_control.sv */
// Self-checking bench for the flash operation controller
`include "fpoc_map.svh"
module test_flash_program_op_control;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Signals and design
  // ------------------------------------------------------------
  localparam logic [7:0] o_ctl = `FPOC_OFF_CTRL;
  localparam logic [7:0] o_key = `FPOC_OFF_KEY;
  localparam logic [7:0] o_adr = `FPOC_OFF_ADDR;
  localparam logic [7:0] o_prt = `FPOC_OFF_PROT;
  localparam logic [7:0] o_cfg = `FPOC_OFF_CFG;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic sys_rst_n = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  fpoc_pkg::fpoc_req_t req;
  fpoc_pkg::fpoc_req_t last_req;
  fpoc_pkg::fpoc_rsp_t rsp = 2'h2;
  logic low_supply = 1'h0;
  logic bank_swap;
  int fail_count = 0;
  int checks = 0;
  int req_cnt = 0;
  logic [31:0] seed = 32'h0000_c67e;
  logic [31:0] r;
  logic [31:0] ta;
  logic swp = 1'h0;

  always #5 hclk = ~hclk;

  // Short operation time keeps the run brief
  fpoc_ctrl #(.OP_CYC(4)) i_fpoc_ctrl (
    .hclk(hclk), .hresetn(hresetn), .sys_rst_n(sys_rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .flash_req(req), .flash_rsp(rsp), .low_supply(low_supply),
    .bank_swap(bank_swap));

  always @(posedge hclk) begin
    if (req.valid === 1'h1) begin
      req_cnt <= req_cnt + 1;
      last_req <= req;
    end
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Flags are {launch, arm, fail, low}
  function automatic logic [31:0] cw(input logic [3:0] f,
                                     input logic [3:0] op);
    logic [31:0] v;
    v = 32'h0;
    v[`FPOC_BIT_GO] = f[3];
    v[`FPOC_BIT_ARM] = f[2];
    v[`FPOC_BIT_FAIL] = f[1];
    v[`FPOC_BIT_LOW] = f[0];
    v[`FPOC_BIT_SWAP] = swp;
    v[3:0] = op;
    return v;
  endfunction : cw

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Zero wait states are not assumed: both phases wait for ready
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'h1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    ahb(1'h0, a, 32'h0);
  endtask : rd

  task automatic go(input logic [3:0] op);
    int i;
    wr(o_ctl, cw(4'h0, op));
    wr(o_ctl, cw(4'h4, op));
    wr(o_key, `FPOC_KEY1);
    wr(o_key, `FPOC_KEY2);
    wr(o_ctl, cw(4'hc, op));
    i = 0;
    do begin
      rd(o_ctl);
      i++;
    end while (r[`FPOC_BIT_GO] === 1'h1 && i < 40);
    chk("launch cleared", 32'h0, {31'h0, r[`FPOC_BIT_GO]});
    wr(o_ctl, cw(4'h0, op));
  endtask : go

  // Clear the flags first, then launch and check the outcome
  task automatic run(input logic [3:0] op, input logic [1:0] er,
                     input logic [1:0] fl);
    int n;
    go(4'h0);
    n = req_cnt;
    go(op);
    chk("request count", {30'h0, er}, req_cnt - n);
    rd(o_ctl);
    chk("control", cw({2'h0, fl}, op), r);
  endtask : run

  task automatic stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    sys_rst_n <= 1'h1;
    rd(o_ctl);
    chk("control reset", 32'h0, r);
    rd(o_key);
    chk("key reset", 32'h0, r);
    wr(o_key, xs());
    rd(o_key);
    chk("key readback", 32'h0, r);
    rd(8'h20);
    chk("unmapped", 32'h0, r);
    wr(o_cfg, 32'h1);
    wr(o_prt, 32'h0001_0000);
    wr(o_ctl, cw(4'h4, 4'h4));
    wr(o_ctl, cw(4'h4, 4'h2));
    rd(o_ctl);
    chk("op while armed", cw(4'h4, 4'h4), r);
    wr(o_ctl, cw(4'hc, 4'h4));
    rd(o_ctl);
    chk("launch locked", cw(4'h4, 4'h4), r);
    wr(o_key, `FPOC_KEY1);
    wr(o_key, xs() | 32'h1);
    wr(o_key, `FPOC_KEY2);
    wr(o_ctl, cw(4'hc, 4'h4));
    rd(o_ctl);
    chk("broken unlock", cw(4'h4, 4'h4), r);
    chk("no request", 32'h0, req_cnt);
    wr(o_ctl, cw(4'h0, 4'h4));
    ta = 32'h0002_0000 | (xs() & 32'h0000_3fff);
    wr(o_adr, ta);
    run(4'h4, 2'h1, 2'h0);
    chk("page address", ta[31:14], last_req.addr[31:14]);
    chk("page op", 32'h4, last_req.op);
    wr(o_adr, 32'h0000_4000 | (xs() & 32'h0000_3fff));
    run(4'h4, 2'h0, 2'h2);
    wr(o_adr, 32'h0002_0800 | (xs() & 32'h0000_07ff));
    run(4'h3, 2'h1, 2'h0);
    run(4'h2, 2'h1, 2'h0);
    run(4'h1, 2'h1, 2'h0);
    chk("word no ecc", 32'h1, last_req.no_ecc);
    wr(o_cfg, 32'h0);
    run(4'h1, 2'h0, 2'h0);
    run(4'h7, 2'h0, 2'h2);
    run(4'h5, 2'h0, 2'h2);
    run(4'h6, 2'h1, 2'h0);
    wr(o_prt, 32'h0);
    run(4'h7, 2'h1, 2'h0);
    run(4'h5, 2'h1, 2'h0);
    for (int k = 8; k < 16; k++) run(4'(k), 2'h0, 2'h2);
    go(4'h0);
    wr(o_ctl, cw(4'h3, 4'h0));
    rd(o_ctl);
    chk("flags read only", cw(4'h0, 4'h0), r);
    rsp <= 2'h3;
    run(4'h4, 2'h1, 2'h2);
    rsp <= 2'h2;
    low_supply <= 1'h1;
    run(4'h4, 2'h1, 2'h1);
    low_supply <= 1'h0;
    swp = 1'h1;
    run(4'h4, 2'h1, 2'h0);
    chk("bank swap", 32'h1, bank_swap);
    chk("request swap", 32'h1, last_req.swap);
    run(4'h8, 2'h0, 2'h2);
    wr(o_ctl, cw(4'h4, 4'h8));
    sys_rst_n <= 1'h0;
    repeat (2) @(posedge hclk);
    sys_rst_n <= 1'h1;
    swp = 1'h0;
    rd(o_ctl);
    chk("other reset", cw(4'h6, 4'h8), r);
    chk("swap reset", 32'h0, bank_swap);
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    rd(o_ctl);
    chk("power reset", 32'h0, r);
    stop_test();
  end
endmodule : test_flash_program_op_control
